// [pkg/gfs_pkg.sv]
// constants for the pin function select and oscillator calibration block
// assumes a register port fed by the serial interface engine
package gfs_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_RATIO = 8'h0A;
  localparam logic [7:0] ADDR_FUNC = 8'h0B;
  localparam logic [7:0] ADDR_KEY = 8'h0D;
  localparam logic [15:0] RST_FUNC = 16'h0000;
  localparam logic [15:0] RST_KEY = 16'h0000;
  localparam logic [11:0] RST_RATIO = 12'h000;
  localparam int SEL0_LSB = 0;
  localparam int SEL1_LSB = 8;
  localparam logic [11:0] RATIO_MAX = 12'hFFF;
  localparam logic [11:0] RATIO_NOMINAL = 12'h7D0;
  // ----------------------------------------
  // unlock keys
  // ----------------------------------------
  localparam logic [15:0] KEY_ALWAYS = 16'h04AD;
  localparam logic [15:0] KEY_PIN0 = 16'h44AD;
  localparam logic [15:0] KEY_PIN1 = 16'h84AD;
  localparam logic [15:0] KEY_BOTH = 16'hC4AD;
  // ----------------------------------------
  // function codes
  // ----------------------------------------
  localparam logic [4:0] FN_LEGACY = 5'h00;
  localparam logic [4:0] FN_IRQ = 5'h01;
  localparam logic [4:0] FN_FRAME = 5'h02;
  localparam logic [4:0] FN_LED_A = 5'h05;
  localparam logic [4:0] FN_LED_B = 5'h06;
  localparam logic [4:0] FN_LED_AB = 5'h07;
  localparam logic [4:0] FN_DATA_A = 5'h0C;
  localparam logic [4:0] FN_DATA_B = 5'h0D;
  localparam logic [4:0] FN_DATA_AB = 5'h0E;
  localparam logic [4:0] FN_TOGGLE = 5'h0F;
  localparam logic [4:0] FN_LOW = 5'h10;
  localparam logic [4:0] FN_HIGH = 5'h11;
  localparam logic [4:0] FN_OSC = 5'h13;
  typedef enum logic [1:0] {CAL_IDLE, CAL_HALF1, CAL_HALF2} gfs_cal_e;
endpackage

// [hdl/gfs_top.sv]
// pin function select, slow/fast oscillator ratio and address unlock key
// assumes all event inputs other than osc32k_i are synchronous pulses or levels on mclk_i
`timescale 1ns/10ps
module gfs_top (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic fast_osc_calibrate_enable_i,
  input wire logic osc32k_i,
  input wire logic irq_i,
  input wire logic slot_first_start_i,
  input wire logic slot_last_end_i,
  input wire logic led_pulse_a_i,
  input wire logic led_pulse_b_i,
  input wire logic data_cycle_a_i,
  input wire logic data_cycle_b_i,
  input wire logic sample_tick_i,
  input wire logic pin0_level_i,
  input wire logic pin1_level_i,
  output logic general_pin_0_o,
  output logic general_pin_1_o,
  output logic addr_change_allowed_o
);
  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [15:0] func_sel;
  logic [15:0] next_func_sel;
  logic [15:0] key;
  logic [15:0] next_key;
  logic [15:0] next_rdata;
  logic [11:0] ratio;
  logic [4:0] sel [2];

  assign sel[0] = func_sel[gfs_pkg::SEL0_LSB +: 5];
  assign sel[1] = func_sel[gfs_pkg::SEL1_LSB +: 5];

  always_comb begin
    next_func_sel = func_sel;
    next_key = key;
    next_rdata = reg_rdata_o;
    if (reg_wr_i && reg_addr_i == gfs_pkg::ADDR_FUNC) begin
      next_func_sel = 16'h0000;
      next_func_sel[gfs_pkg::SEL0_LSB +: 5] = reg_wdata_i[gfs_pkg::SEL0_LSB +: 5];
      next_func_sel[gfs_pkg::SEL1_LSB +: 5] = reg_wdata_i[gfs_pkg::SEL1_LSB +: 5];
    end
    if (reg_wr_i && reg_addr_i == gfs_pkg::ADDR_KEY) begin
      next_key = reg_wdata_i;
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        gfs_pkg::ADDR_RATIO: next_rdata = {4'h0, ratio};
        gfs_pkg::ADDR_FUNC: next_rdata = func_sel;
        gfs_pkg::ADDR_KEY: next_rdata = key;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      func_sel <= gfs_pkg::RST_FUNC;
      key <= gfs_pkg::RST_KEY;
      reg_rdata_o <= 16'h0000;
    end else begin
      func_sel <= next_func_sel;
      key <= next_key;
      reg_rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------
  // address unlock
  // ----------------------------------------
  logic next_allow;

  always_comb begin
    case (key)
      gfs_pkg::KEY_ALWAYS: next_allow = 1'b1;
      gfs_pkg::KEY_PIN0: next_allow = pin0_level_i;
      gfs_pkg::KEY_PIN1: next_allow = pin1_level_i;
      gfs_pkg::KEY_BOTH: next_allow = pin0_level_i & pin1_level_i;
      default: next_allow = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      addr_change_allowed_o <= 1'b0;
    end else begin
      addr_change_allowed_o <= next_allow;
    end
  end

  // ----------------------------------------
  // oscillator ratio
  // ----------------------------------------
  // slow clock is async to mclk_i; sync_a feeds only sync_b
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic rise;
  gfs_pkg::gfs_cal_e cal_state;
  gfs_pkg::gfs_cal_e next_cal_state;
  logic [11:0] cal_cnt;
  logic [11:0] next_cal_cnt;
  logic [11:0] next_ratio;
  logic store;

  assign rise = sync_b & ~sync_c;

  always_comb begin
    next_cal_state = cal_state;
    next_cal_cnt = cal_cnt;
    next_ratio = ratio;
    store = 1'b0;
    // saturate rather than wrap when the fast clock runs well above nominal
    if (cal_cnt != gfs_pkg::RATIO_MAX) begin
      next_cal_cnt = cal_cnt + 12'h001;
    end
    case (cal_state)
      gfs_pkg::CAL_IDLE: begin
        if (fast_osc_calibrate_enable_i && rise) begin
          next_cal_state = gfs_pkg::CAL_HALF1;
          next_cal_cnt = 12'h001;
        end
      end
      gfs_pkg::CAL_HALF1: begin
        if (rise) begin
          next_cal_state = gfs_pkg::CAL_HALF2;
        end
      end
      gfs_pkg::CAL_HALF2: begin
        if (rise) begin
          store = 1'b1;
          next_ratio = cal_cnt;
          next_cal_state = gfs_pkg::CAL_HALF1;
          next_cal_cnt = 12'h001;
        end
      end
      default: next_cal_state = gfs_pkg::CAL_IDLE;
    endcase
    if (!fast_osc_calibrate_enable_i) begin
      next_cal_state = gfs_pkg::CAL_IDLE;
      store = 1'b0;
      next_ratio = ratio;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
      cal_state <= gfs_pkg::CAL_IDLE;
      cal_cnt <= 12'h000;
      ratio <= gfs_pkg::RST_RATIO;
    end else begin
      sync_a <= osc32k_i;
      sync_b <= sync_a;
      sync_c <= sync_b;
      cal_state <= next_cal_state;
      cal_cnt <= next_cal_cnt;
      ratio <= next_ratio;
    end
  end

  // ----------------------------------------
  // shared sources
  // ----------------------------------------
  logic frame;
  logic next_frame;
  logic toggle;
  logic next_toggle;

  always_comb begin
    next_frame = frame;
    if (slot_first_start_i) begin
      next_frame = 1'b1;
    end else if (slot_last_end_i) begin
      next_frame = 1'b0;
    end
    next_toggle = toggle ^ sample_tick_i;
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      frame <= 1'b0;
      toggle <= 1'b0;
    end else begin
      frame <= next_frame;
      toggle <= next_toggle;
    end
  end

  // ----------------------------------------
  // per-pin output mux
  // ----------------------------------------
  logic [1:0] pin_q;
  logic [1:0] next_pin;

  assign general_pin_0_o = pin_q[0];
  assign general_pin_1_o = pin_q[1];

  for (genvar p = 0; p < 2; p++) begin : g_pin
    always_comb begin
      case (sel[p])
        gfs_pkg::FN_LEGACY: next_pin[p] = (p == 0) ? irq_i : 1'b0;
        gfs_pkg::FN_IRQ: next_pin[p] = irq_i;
        gfs_pkg::FN_FRAME: next_pin[p] = frame;
        gfs_pkg::FN_LED_A: next_pin[p] = led_pulse_a_i;
        gfs_pkg::FN_LED_B: next_pin[p] = led_pulse_b_i;
        gfs_pkg::FN_LED_AB: next_pin[p] = led_pulse_a_i | led_pulse_b_i;
        gfs_pkg::FN_DATA_A: next_pin[p] = data_cycle_a_i;
        gfs_pkg::FN_DATA_B: next_pin[p] = data_cycle_b_i;
        gfs_pkg::FN_DATA_AB: next_pin[p] = data_cycle_a_i | data_cycle_b_i;
        gfs_pkg::FN_TOGGLE: next_pin[p] = toggle;
        gfs_pkg::FN_LOW: next_pin[p] = 1'b0;
        gfs_pkg::FN_HIGH: next_pin[p] = 1'b1;
        gfs_pkg::FN_OSC: next_pin[p] = sync_b;
        // unsupported codes park low
        default: next_pin[p] = 1'b0;
      endcase
    end
  end

  // registered output, no combinational glitch on switch
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_q <= 2'b00;
    end else begin
      pin_q <= next_pin;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_tick0;
    sel[0] == gfs_pkg::FN_TOGGLE && sample_tick_i ##1 sel[0] == gfs_pkg::FN_TOGGLE;
  endsequence

  a_ratio_hold: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    $changed(ratio) |-> $past(store)) else $error("ratio changed without window end");
  a_ratio_enable: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !fast_osc_calibrate_enable_i |=> $stable(ratio)) else $error("ratio moved while disabled");
  a_key_open: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    key == gfs_pkg::KEY_ALWAYS |=> addr_change_allowed_o) else $error("open key not honoured");
  a_key_pin0: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    key == gfs_pkg::KEY_PIN0 |=> addr_change_allowed_o == $past(pin0_level_i))
    else $error("pin0 key wrong");
  a_key_both: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    key == gfs_pkg::KEY_BOTH && !(pin0_level_i && pin1_level_i) |=> !addr_change_allowed_o)
    else $error("both-pin key opened early");
  a_pin_const: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    sel[1] == gfs_pkg::FN_HIGH |=> general_pin_1_o) else $error("pin1 not high");
  a_irq_route: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    sel[1] == gfs_pkg::FN_IRQ |=> general_pin_1_o == $past(irq_i)) else $error("irq not routed");
  a_toggle_rate: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    s_tick0 |=> general_pin_0_o != $past(general_pin_0_o)) else $error("toggle missed");
  a_sel_write: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    reg_wr_i && reg_addr_i == gfs_pkg::ADDR_FUNC |=> sel[0] == $past(reg_wdata_i[4:0]))
    else $error("select write lost");
endmodule

// [verif/gfs_host_model.sv]
// host-side model: free-running slow oscillator and pad readback
// assumes push-pull pads, so a pad reads back what the block drives
`timescale 1ns/10ps
module gfs_host_model #(
  parameter real HALF_NS = 503.0
) (
  input wire logic general_pin_0_i,
  input wire logic general_pin_1_i,
  input wire logic slow_i,
  output logic osc32k_o,
  output logic pin0_level_o,
  output logic pin1_level_o
);
  // odd half period keeps the slow clock out of phase with mclk_i
  // slow_i doubles the period so a stale ratio differs from a fresh one
  initial begin
    osc32k_o = 1'b0;
    forever #((slow_i === 1'b1) ? 2.0 * HALF_NS : HALF_NS) osc32k_o = ~osc32k_o;
  end
  assign pin0_level_o = general_pin_0_i;
  assign pin1_level_o = general_pin_1_i;
endmodule

// [verif/tb_top.sv]
// self-checking bench for pin function select, ratio and unlock key
// assumes the host model supplies the slow oscillator and pad levels
`timescale 1ns/10ps
module tb_top;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic fast_osc_calibrate_enable_i = 1'b0;
  logic osc_slow = 1'b0;
  logic [7:0] sv = 8'h00;
  logic [15:0] reg_rdata_o;
  logic general_pin_0_o, general_pin_1_o, addr_change_allowed_o;
  wire osc32k_i, pin0_level_i, pin1_level_i;
  logic [15:0] d, d1;
  logic [11:0] rows [13];
  logic [15:0] keys [5];
  int err_total = 0;
  int comparisons = 0;
  int m;
  gfs_top gfs_top_inst (.mclk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .fast_osc_calibrate_enable_i, .osc32k_i, .irq_i(sv[7]),
    .led_pulse_a_i(sv[6]), .led_pulse_b_i(sv[5]), .data_cycle_a_i(sv[4]),
    .data_cycle_b_i(sv[3]), .sample_tick_i(sv[2]), .slot_first_start_i(sv[1]),
    .slot_last_end_i(sv[0]), .pin0_level_i, .pin1_level_i, .general_pin_0_o,
    .general_pin_1_o, .addr_change_allowed_o);
  gfs_host_model gfs_host_model_inst (.general_pin_0_i(general_pin_0_o),
    .general_pin_1_i(general_pin_1_o), .slow_i(osc_slow), .osc32k_o(osc32k_i),
    .pin0_level_o(pin0_level_i), .pin1_level_o(pin1_level_i));
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic cyc(int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] v);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [15:0] v);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    cyc(1);
    v = reg_rdata_o;
  endtask
  task automatic pulse(int k);
    @(posedge mclk_i);
    sv[k] <= 1'b1;
    @(posedge mclk_i);
    sv[k] <= 1'b0;
  endtask
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic end_of_test();
    if (err_total == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    // row: select, sources irq/led a/led b/data a/data b, pin0, pin1
    rows = '{{5'h01, 5'h10, 2'h3}, {5'h01, 5'h00, 2'h0}, {5'h05, 5'h08, 2'h3},
      {5'h06, 5'h08, 2'h0}, {5'h07, 5'h04, 2'h3}, {5'h0C, 5'h02, 2'h3},
      {5'h0C, 5'h01, 2'h0}, {5'h0D, 5'h01, 2'h3}, {5'h0E, 5'h01, 2'h3},
      {5'h10, 5'h1F, 2'h0}, {5'h11, 5'h00, 2'h3}, {5'h03, 5'h1F, 2'h0},
      {5'h00, 5'h10, 2'h2}};
    keys = '{16'h04AD, 16'h44AD, 16'h84AD, 16'hC4AD, 16'h04AE};
    repeat (8) @(posedge mclk_i);
    resetn_i <= 1'b1;
    for (int a = 10; a < 14; a++) begin
      rd(8'(a), d);
      chk("reset_value", d, 16'h0000);
    end
    wr(8'h0B, 16'hFFFF);
    rd(8'h0B, d);
    chk("func_reserved", d, 16'h1F1F);
    wr(8'h0A, 16'hFFFF);
    wr(8'h0C, 16'hFFFF);
    rd(8'h0A, d);
    chk("ratio_ro", d, 16'h0000);
    rd(8'h0C, d);
    chk("unmapped", d, 16'h0000);
    foreach (rows[i]) begin
      @(posedge mclk_i);
      sv <= {rows[i][6:2], 3'h0};
      wr(8'h0B, {3'h0, rows[i][11:7], 3'h0, rows[i][11:7]});
      cyc(3);
      chk("pin0", 16'(general_pin_0_o), 16'(rows[i][1]));
      chk("pin1", 16'(general_pin_1_o), 16'(rows[i][0]));
    end
    wr(8'h0B, 16'h0F0F);
    for (int j = 0; j < 2; j++) begin
      cyc(3);
      d1 = 16'(general_pin_0_o);
      pulse(2);
      cyc(3);
      chk("toggle", 16'(general_pin_0_o), d1 ^ 16'h0001);
    end
    wr(8'h0B, 16'h0202);
    pulse(1);
    cyc(6);
    chk("frame_on", 16'(general_pin_1_o), 16'h0001);
    pulse(0);
    cyc(3);
    chk("frame_off", 16'(general_pin_1_o), 16'h0000);
    // pads forced through the constant codes, then every key tried
    // address byte untouched; only the key is written
    for (int p = 0; p < 4; p++) begin
      wr(8'h0B, {3'h0, 4'h8, p[1], 3'h0, 4'h8, p[0]});
      for (int k = 0; k < 5; k++) begin
        wr(8'h0D, keys[k]);
        cyc(3);
        m = (k == 0) || (k == 1 && p[0]) || (k == 2 && p[1]) || (k == 3 && p == 3);
        chk("allow", 16'(addr_change_allowed_o), 16'(m));
        rd(8'h0D, d);
        chk("key", d, keys[k]);
      end
    end
    wr(8'h0B, 16'h1300);
    fast_osc_calibrate_enable_i <= 1'b1;
    m = 0;
    for (int j = 0; j < 100; j++) begin
      cyc(1);
      m += int'(general_pin_1_o === osc32k_i);
    end
    chk("osc_out", 16'(m > 88), 16'h0001);
    d = 16'h0000;
    for (int j = 0; j < 200 && d === 16'h0000; j++) rd(8'h0A, d);
    // two slow periods of 1006 ns at 10 ns give 201 or 202
    chk("ratio", 16'(d >= 16'h00C8 && d <= 16'h00CB), 16'h0001);
    @(posedge mclk_i);
    fast_osc_calibrate_enable_i <= 1'b0;
    // a still-running window would now count about twice as many cycles
    osc_slow <= 1'b1;
    cyc(1300);
    rd(8'h0A, d1);
    chk("ratio_hold", d1, d);
    // mid-run reset clears registers, pins and the allow level
    wr(8'h0D, 16'h04AD);
    cyc(2);
    chk("pre_allow", 16'(addr_change_allowed_o), 16'h0001);
    @(posedge mclk_i);
    resetn_i <= 1'b0;
    cyc(2);
    chk("rst_pin0", 16'(general_pin_0_o), 16'h0000);
    chk("rst_allow", 16'(addr_change_allowed_o), 16'h0000);
    @(posedge mclk_i);
    resetn_i <= 1'b1;
    rd(8'h0B, d);
    chk("rst_func", d, 16'h0000);
    rd(8'h0D, d);
    chk("rst_key", d, 16'h0000);
    rd(8'h0A, d);
    chk("rst_ratio", d, 16'h0000);
    chk("rel_pin0", 16'(general_pin_0_o), 16'h0001);
    end_of_test();
  end
endmodule
